// >>> xe_cfg.svh
// constants for the external-instruction execution and timing unit
`ifndef XE_CFG_SVH
`define XE_CFG_SVH

// opcode field, word bits 15:5
`define XE_OP_IDLE 11'h01a
`define XE_OP_STATUS_CLEAR_OP 11'h01b
`define XE_OP_UOPB 11'h01d
`define XE_OP_UOPA 11'h01e
`define XE_OP_UOPC 11'h01f

// upper address line codes, a0 in bit 2
`define XE_CODE_IDLE 3'h2
`define XE_CODE_STATUS_CLEAR_OP 3'h3
`define XE_CODE_UOPA 3'h6
`define XE_CODE_UOPB 3'h5
`define XE_CODE_UOPC 3'h7

// jump opcode range on word bits 15:8
`define XE_JMP_LO 8'h10
`define XE_JMP_HI 8'h1c

// field positions in the address output, a0 is the top bit
`define XE_ADDR_CODE_HI 15
`define XE_ADDR_CODE_LO 13
`define XE_ADDR_C_HI 12
`define XE_ADDR_C_LO 8

// base counts
`define XE_EXT_CLK 7'h0a
`define XE_EXT_MEM 4'h1
`define XE_JMP_CLK 7'h06
`define XE_JMP_MEM 4'h1

// operand address modification: extra clocks and memory cycles
`define XE_MODE_WR 2'h0
`define XE_MODE_IND 2'h1
`define XE_MODE_SYMIDX 2'h2
`define XE_MODE_AINC 2'h3
`define XE_IND_CLK 4'h4
`define XE_IND_MEM 4'h1
`define XE_AINC_CLK 4'h6
`define XE_AINC_MEM 4'h2
`define XE_SYM_CLK 4'h6
`define XE_SYM_MEM 4'h1
`define XE_IDX_CLK 4'h6
`define XE_IDX_MEM 4'h2

// status clear keeps bits 0..6 (msb numbering), zeroes 7..15
`define XE_ST_KEEP_MASK 16'hfe00
`define XE_ST_RESET 16'h0000

`endif

// >>> xe_pkg.sv
// types for the external-instruction execution and timing unit
package xe_pkg;

  typedef enum logic [1:0] {
    XE_READY,
    XE_EXEC,
    XE_HALT
  } xe_state_t;

endpackage

// >>> xe_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module xe_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // async level in, synchronised level out
  input wire logic pin_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// >>> xe_exec_timing.sv
// execution and cycle timing of external-control and jump instructions
`timescale 1ns/1ns
`include "xe_cfg.svh"

// Summary of operation
// - external-control op drives its fixed three-bit code on the top address lines
// - the 5-bit C field goes out on address lines A3 to A7
// - read strobe asserted and one bit-I/O clock pulse emitted per external op
// - idle halts execution until interrupt, load request or reset
// - cycle-end output low from the edge starting each final clock
// - each bit-serial I/O wait state adds exactly one clock
// - memory wait states add wait count times memory accesses to clocks
// - non-register addressing adds its own clocks and memory cycles on top
// - jump takes 6 clocks and 1 memory cycle, taken or not
// - bit-serial I/O base counts assume no waits; waits extend beyond base
module xe_exec_timing (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction issue, same clock domain
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [6:0] base_clk,
  input wire logic [3:0] base_mem,
  input wire logic [4:0] cru_ops,
  input wire logic uses_src,
  input wire logic uses_dst,
  input wire logic [2:0] mem_wait,
  // status register load, same clock domain
  input wire logic status_wr,
  input wire logic [15:0] status_wdata,
  // pins from outside
  input wire logic bit_io_ready,
  input wire logic intr_req,
  input wire logic load_req,
  // outputs
  output logic instr_ready,
  output logic instr_done,
  output logic halted,
  output logic [15:0] addr_out,
  output logic read_direction_strobe,
  output logic bit_io_clock_pulse,
  output logic cycle_end_output_n,
  output logic [15:0] status_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins

  logic ready_s;
  logic intr_s;
  logic load_s;

  xe_sync2 #(.RST_VAL(1'b1)) u_sync_ready (.clk(clk), .nrst(nrst), .pin_in(bit_io_ready), .sync_out(ready_s));
  xe_sync2 #(.RST_VAL(1'b0)) u_sync_intr (.clk(clk), .nrst(nrst), .pin_in(intr_req), .sync_out(intr_s));
  xe_sync2 #(.RST_VAL(1'b0)) u_sync_load (.clk(clk), .nrst(nrst), .pin_in(load_req), .sync_out(load_s));

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [7:0] mode_cost(input logic [1:0] mode, input logic [3:0] field);
    logic [7:0] r;
    r = 8'h00;
    unique case (mode)
      `XE_MODE_WR: r = 8'h00;
      `XE_MODE_IND: r = {`XE_IND_CLK, `XE_IND_MEM};
      `XE_MODE_AINC: r = {`XE_AINC_CLK, `XE_AINC_MEM};
      `XE_MODE_SYMIDX: r = (field == 4'h0) ? {`XE_SYM_CLK, `XE_SYM_MEM} : {`XE_IDX_CLK, `XE_IDX_MEM};
    endcase
    return r;
  endfunction

  xe_pkg::xe_state_t state_ff;
  xe_pkg::xe_state_t nxt_state;

  wire [10:0] opcode = instr_word[15:5];
  wire is_idle = (opcode == `XE_OP_IDLE);
  wire is_status_clear_op = (opcode == `XE_OP_STATUS_CLEAR_OP);
  wire is_ext = is_idle | is_status_clear_op | (opcode == `XE_OP_UOPA) | (opcode == `XE_OP_UOPB) | (opcode == `XE_OP_UOPC);
  wire is_jump = (instr_word[15:8] >= `XE_JMP_LO) && (instr_word[15:8] <= `XE_JMP_HI);
  wire fixed_op = is_ext | is_jump;
  wire [2:0] ext_code = is_idle ? `XE_CODE_IDLE :
                        is_status_clear_op ? `XE_CODE_STATUS_CLEAR_OP :
                        (opcode == `XE_OP_UOPA) ? `XE_CODE_UOPA :
                        (opcode == `XE_OP_UOPB) ? `XE_CODE_UOPB : `XE_CODE_UOPC;
  wire start = (state_ff == xe_pkg::XE_READY) && instr_valid;

  // operand extras, only for issue that carries general operands
  wire [7:0] src_cost = (uses_src && !fixed_op) ? mode_cost(instr_word[5:4], instr_word[3:0]) : 8'h00;
  wire [7:0] dst_cost = (uses_dst && !fixed_op) ? mode_cost(instr_word[11:10], instr_word[9:6]) : 8'h00;
  wire [6:0] sel_clk = is_ext ? `XE_EXT_CLK : is_jump ? `XE_JMP_CLK : base_clk;
  wire [3:0] sel_mem = is_ext ? `XE_EXT_MEM : is_jump ? `XE_JMP_MEM : base_mem;
  wire [4:0] sel_cru = fixed_op ? 5'h00 : cru_ops;
  wire [4:0] mem_tot = 5'(sel_mem) + 5'(src_cost[3:0]) + 5'(dst_cost[3:0]);
  wire [7:0] mem_pen = 8'(mem_tot * mem_wait);
  wire [8:0] raw_tot = 9'(sel_clk) + 9'(src_cost[7:4]) + 9'(dst_cost[7:4]) + 9'(mem_pen);
  wire [8:0] total = (raw_tot == 9'h000) ? 9'h001 : raw_tot;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  logic [8:0] cnt_ff;
  logic [4:0] cru_left_ff;
  logic phase_ff;
  logic first_ff;
  logic ext_ff;
  logic idle_ff;

  // wait state: ready sampled at the start of the second clock of an I/O op
  wire cru_stall = (state_ff == xe_pkg::XE_EXEC) && (cru_left_ff != 5'h00) && phase_ff && !ready_s;
  wire fin = (state_ff == xe_pkg::XE_EXEC) && (cnt_ff == 9'h001) && !cru_stall;
  wire wake = intr_s | load_s;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      xe_pkg::XE_READY: if (instr_valid) nxt_state = xe_pkg::XE_EXEC;
      xe_pkg::XE_EXEC: if (fin) nxt_state = idle_ff ? xe_pkg::XE_HALT : xe_pkg::XE_READY;
      xe_pkg::XE_HALT: if (wake) nxt_state = xe_pkg::XE_READY;
    endcase
  end

  // counter holds on a wait, so each wait adds exactly one clock
  wire [8:0] nxt_cnt = start ? total : (state_ff == xe_pkg::XE_EXEC && !cru_stall) ? cnt_ff - 9'h001 : cnt_ff;
  wire nxt_phase = start ? 1'b0 : (state_ff == xe_pkg::XE_EXEC && !cru_stall) ? ~phase_ff : phase_ff;
  wire [4:0] nxt_cru = start ? sel_cru :
                       (state_ff == xe_pkg::XE_EXEC && phase_ff && !cru_stall && cru_left_ff != 5'h00) ?
                       cru_left_ff - 5'h01 : cru_left_ff;
  wire nxt_exec = (nxt_state == xe_pkg::XE_EXEC);
  wire nxt_cyc_end = nxt_exec && (nxt_phase || nxt_cnt == 9'h001);
  wire nxt_pulse = (state_ff == xe_pkg::XE_EXEC) && ext_ff && first_ff && !phase_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= xe_pkg::XE_READY;
      cnt_ff <= 9'h000;
      cru_left_ff <= 5'h00;
      phase_ff <= 1'b0;
      first_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cru_left_ff <= nxt_cru;
      phase_ff <= nxt_phase;
      first_ff <= start | (first_ff & ~(phase_ff & ~cru_stall));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external signalling and outputs

  logic [15:0] addr_ff;
  logic rd_strobe_ff;
  logic pulse_ff;
  logic cyc_end_n_ff;
  logic ready_ff;
  logic done_ff;
  logic halted_ff;
  logic [15:0] status_ff;

  wire [15:0] ext_addr = {ext_code, instr_word[4:0], 8'h00};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_ff <= 1'b0;
      idle_ff <= 1'b0;
      addr_ff <= 16'h0000;
      rd_strobe_ff <= 1'b0;
    end else if (start) begin
      ext_ff <= is_ext;
      idle_ff <= is_idle;
      addr_ff <= is_ext ? ext_addr : 16'h0000;
      rd_strobe_ff <= is_ext;
    end else if (fin) begin
      ext_ff <= 1'b0;
      addr_ff <= 16'h0000;
      rd_strobe_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_ff <= 1'b0;
      cyc_end_n_ff <= 1'b1;
      ready_ff <= 1'b1;
      done_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      pulse_ff <= nxt_pulse;
      cyc_end_n_ff <= ~nxt_cyc_end;
      ready_ff <= (nxt_state == xe_pkg::XE_READY);
      done_ff <= fin;
      halted_ff <= (nxt_state == xe_pkg::XE_HALT);
    end
  end

  // status clear takes priority over a same-cycle load of the low bits
  wire [15:0] st_loaded = status_wr ? status_wdata : status_ff;
  wire [15:0] nxt_status = (start && is_status_clear_op) ? (st_loaded & `XE_ST_KEEP_MASK) : st_loaded;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_ff <= `XE_ST_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign instr_ready = ready_ff;
  assign instr_done = done_ff;
  assign halted = halted_ff;
  assign addr_out = addr_ff;
  assign read_direction_strobe = rd_strobe_ff;
  assign bit_io_clock_pulse = pulse_ff;
  assign cycle_end_output_n = cyc_end_n_ff;
  assign status_bits = status_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ext_code;
    start && is_ext |=> addr_ff[15:13] == $past(ext_code) throughout (state_ff == xe_pkg::XE_EXEC) [*2];
  endproperty
  a_ext_code: assert property (p_ext_code) else $error("external code wrong on top address lines");

  property p_c_field;
    start && is_ext |=> addr_ff[12:8] == $past(instr_word[4:0]);
  endproperty
  a_c_field: assert property (p_c_field) else $error("c field not on address lines");

  property p_ext_strobe;
    start && is_ext |=> rd_strobe_ff && !pulse_ff ##1 pulse_ff && rd_strobe_ff ##1 !pulse_ff;
  endproperty
  a_ext_strobe: assert property (p_ext_strobe) else $error("strobe or bit-io pulse misplaced");

  property p_idle_halt;
    fin && idle_ff && !wake |=> halted_ff && !ready_ff;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("idle did not halt");

  property p_cycle_end;
    (state_ff == xe_pkg::XE_EXEC) && (cnt_ff == 9'h001) |-> !cyc_end_n_ff;
  endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("cycle end not low on final clock");

  property p_cru_wait;
    cru_stall |=> cnt_ff == $past(cnt_ff) && state_ff == xe_pkg::XE_EXEC;
  endproperty
  a_cru_wait: assert property (p_cru_wait) else $error("wait state did not hold the count");

  property p_mem_wait;
    start && !fixed_op && !uses_src && !uses_dst && base_clk != 7'h00 |=>
      cnt_ff == 9'($past(base_clk)) + 9'($past(base_mem) * $past(mem_wait));
  endproperty
  a_mem_wait: assert property (p_mem_wait) else $error("memory wait penalty wrong");

  property p_addr_mode;
    start && !fixed_op && uses_src && !uses_dst && instr_word[5:4] == `XE_MODE_IND && mem_wait == 3'h0 |=>
      cnt_ff == 9'($past(base_clk)) + 9'h004;
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("indirect mode extra clocks wrong");

  property p_jump;
    start && is_jump |=> cnt_ff == 9'h006 + 9'($past(mem_wait));
  endproperty
  a_jump: assert property (p_jump) else $error("jump cycle count wrong");

  // base count carries no allowance for bit-serial waits, those come later as stalls
  property p_cru_base;
    start && !fixed_op && cru_ops != 5'h00 && !uses_src && !uses_dst && mem_wait == 3'h0 && base_clk != 7'h00 |=>
      cnt_ff == 9'($past(base_clk));
  endproperty
  a_cru_base: assert property (p_cru_base) else $error("bit-serial base count wrong");

  property p_status_clear;
    start && is_status_clear_op |=> status_ff[8:0] == 9'h000;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bits 7-15 not cleared");

  c_ext: cover property (start && is_ext ##2 pulse_ff);
  c_jump: cover property (start && is_jump ##7 done_ff);
  c_wake: cover property (halted_ff ##1 wake ##1 ready_ff);
  c_wait: cover property (cru_stall ##1 cru_stall);

endmodule

// >>> xe_ext_decoder.sv
// external decode logic model that latches the code shown on the address lines
`timescale 1ns/1ns
module xe_ext_decoder (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // lines from the device
  input wire logic [15:0] addr_out,
  input wire logic bit_io_clock_pulse,
  // wait control from the bench
  input wire logic stall_go,
  input wire logic [3:0] stall_len,
  // to the device and the bench
  output logic bit_io_ready,
  output logic [7:0] seen_ff
);
  ////////////////////////////////////////
  logic [3:0] cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
      seen_ff <= 8'h00;
    end else begin
      if (stall_go) begin
        cnt_ff <= stall_len;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
      if (bit_io_clock_pulse) begin
        seen_ff <= addr_out[15:8];
      end
    end
  end
  // slow answer: ready held low while the stall count runs
  assign bit_io_ready = (cnt_ff == 4'h0);
endmodule

// >>> external_instruction_cycle_timing_test.sv
// self-checking bench for the external-instruction execution and timing unit
`timescale 1ns/1ns
`include "xe_cfg.svh"
module external_instruction_cycle_timing_test;
  logic clk, nrst, instr_valid, uses_src, uses_dst, status_wr, bit_io_ready, intr_req, load_req;
  logic [15:0] instr_word, status_wdata, addr_out, status_bits;
  logic [6:0] base_clk;
  logic [3:0] base_mem, stall_len;
  logic [4:0] cru_ops;
  logic [2:0] mem_wait;
  logic instr_ready, instr_done, halted, read_direction_strobe, bit_io_clock_pulse, cycle_end_output_n;
  logic stall_go;
  logic [7:0] seen;
  logic [15:0] addr_seen;
  int n_mismatch, tests_run, n_clk, n_pulse, n_strobe, n_ce, t1, t2;
  ////////////////////////////////////////
  xe_exec_timing i_dut (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
    .base_clk(base_clk), .base_mem(base_mem), .cru_ops(cru_ops), .uses_src(uses_src),
    .uses_dst(uses_dst), .mem_wait(mem_wait), .status_wr(status_wr), .status_wdata(status_wdata),
    .bit_io_ready(bit_io_ready), .intr_req(intr_req), .load_req(load_req), .instr_ready(instr_ready),
    .instr_done(instr_done), .halted(halted), .addr_out(addr_out),
    .read_direction_strobe(read_direction_strobe), .bit_io_clock_pulse(bit_io_clock_pulse),
    .cycle_end_output_n(cycle_end_output_n), .status_bits(status_bits));
  xe_ext_decoder i_far (.clk(clk), .nrst(nrst), .addr_out(addr_out), .bit_io_clock_pulse(bit_io_clock_pulse),
    .stall_go(stall_go), .stall_len(stall_len), .bit_io_ready(bit_io_ready), .seen_ff(seen));
  always #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // issue one instruction and count what the device shows until done
  task automatic issue(input logic [15:0] w, input logic [6:0] bc, input logic [3:0] bm, input logic [4:0] bit_serial_io_unit,
      input logic src, input logic dst, input logic [2:0] mw, input logic [3:0] st);
    int k;
    k = 0;
    @(negedge clk);
    if (st != 4'h0) begin
      stall_len = st;
      stall_go = 1'b1;
      @(negedge clk);
      stall_go = 1'b0;
    end
    instr_word = w;
    base_clk = bc;
    base_mem = bm;
    cru_ops = bit_serial_io_unit;
    uses_src = src;
    uses_dst = dst;
    mem_wait = mw;
    instr_valid = 1'b1;
    while (instr_ready !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    instr_valid = 1'b0;
    n_clk = 1;
    n_pulse = 0;
    n_strobe = 0;
    n_ce = 0;
    addr_seen = 16'h0000;
    while (instr_done !== 1'b1 && n_clk < 200) begin
      n_pulse += (bit_io_clock_pulse === 1'b1);
      n_strobe += (read_direction_strobe === 1'b1);
      n_ce += (cycle_end_output_n === 1'b0);
      if (read_direction_strobe === 1'b1) begin
        addr_seen = addr_out;
      end
      @(negedge clk);
      n_clk++;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_ext_ops();
    logic [10:0] ops [4] = '{`XE_OP_STATUS_CLEAR_OP, `XE_OP_UOPA, `XE_OP_UOPB, `XE_OP_UOPC};
    logic [2:0] codes [4] = '{3'h3, 3'h6, 3'h5, 3'h7};
    logic [4:0] cs [4] = '{5'h00, 5'h1f, 5'h15, 5'h0a};
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      status_wr = 1'b1;
      status_wdata = 16'hffff;
      @(negedge clk);
      status_wr = 1'b0;
      issue({ops[i], cs[i]}, 7'h00, 4'h0, 5'h00, 1'b0, 1'b0, 3'h0, 4'h0);
      check(addr_seen, {codes[i], cs[i], 8'h00});
      check(n_pulse, 1);
      check(n_strobe, 10);
      check(n_clk, 11);
      check(n_ce, 5);
      check(seen, {codes[i], cs[i]});
      check(status_bits, (i == 0) ? 16'hfe00 : 16'hffff);
    end
  endtask
  task automatic t_idle(input bit use_load);
    int k;
    k = 0;
    issue({`XE_OP_IDLE, 5'h09}, 7'h00, 4'h0, 5'h00, 1'b0, 1'b0, 3'h0, 4'h0);
    check(addr_seen, {3'h2, 5'h09, 8'h00});
    repeat (4) @(negedge clk);
    check(halted, 1'b1);
    check(instr_ready, 1'b0);
    instr_valid = 1'b1;
    repeat (2) @(negedge clk);
    instr_valid = 1'b0;
    check(halted, 1'b1);
    if (use_load) begin
      load_req = 1'b1;
    end else begin
      intr_req = 1'b1;
    end
    while (halted !== 1'b0 && k < 8) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    check(halted, 1'b0);
    check(instr_ready, 1'b1);
    intr_req = 1'b0;
    load_req = 1'b0;
  endtask
  task automatic t_counts();
    issue(16'h1005, 7'h00, 4'h0, 5'h00, 1'b0, 1'b0, 3'h2, 4'h0);
    check(n_clk, 9);
    issue(16'h1c3f, 7'h00, 4'h0, 5'h00, 1'b1, 1'b0, 3'h0, 4'h0);
    check(n_clk, 7);
    issue(16'ha000, 7'h0c, 4'h4, 5'h00, 1'b0, 1'b0, 3'h2, 4'h0);
    check(n_clk, 21);
    issue(16'ha020, 7'h0c, 4'h4, 5'h00, 1'b1, 1'b0, 3'h2, 4'h0);
    check(n_clk, 29);
    issue(16'ha420, 7'h0c, 4'h4, 5'h00, 1'b1, 1'b1, 3'h2, 4'h0);
    check(n_clk, 35);
    issue(16'ha023, 7'h0c, 4'h4, 5'h00, 1'b1, 1'b0, 3'h1, 4'h0);
    check(n_clk, 25);
    issue(16'ha030, 7'h0c, 4'h4, 5'h00, 1'b1, 1'b0, 3'h0, 4'h0);
    check(n_clk, 19);
    issue(16'ha010, 7'h0c, 4'h4, 5'h00, 1'b1, 1'b0, 3'h0, 4'h0);
    check(n_clk, 17);
  endtask
  // waits are injected by the far side model holding its ready line low
  task automatic t_bitio_waits();
    issue(16'ha000, 7'h0c, 4'h2, 5'h01, 1'b0, 1'b0, 3'h0, 4'h0);
    check(n_clk, 13);
    issue(16'ha000, 7'h0c, 4'h2, 5'h01, 1'b0, 1'b0, 3'h0, 4'h4);
    t1 = n_clk;
    issue(16'ha000, 7'h0c, 4'h2, 5'h01, 1'b0, 1'b0, 3'h0, 4'h7);
    t2 = n_clk;
    check(t2 - t1, 3);
    check(t1, 17);
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {instr_valid, uses_src, uses_dst, status_wr, intr_req, load_req, stall_go} = 7'h00;
    {instr_word, status_wdata} = 32'h0000_0000;
    {base_clk, base_mem, cru_ops, mem_wait, stall_len} = 23'h000000;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_ext_ops();
    t_idle(1'b0);
    t_idle(1'b1);
    t_counts();
    t_bitio_waits();
    tally_and_finish();
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
